// ### include/gpc_regs.svh
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// Register addresses
`define GPC_ADDR_PIN_ONE_CONTROL 8'h74
`define GPC_ADDR_PIN_TWO_CONTROL 8'h75
`define GPC_ADDR_IRQ_STATUS 8'h7a
`define GPC_ADDR_IRQ_MASK 8'h7b
`define GPC_ADDR_PIN_STATE 8'h7c

// Reset values and writable bits
`define GPC_PIN_ONE_CONTROL_RESET 16'h00a8
`define GPC_PIN_TWO_CONTROL_RESET 16'h00a8
`define GPC_CONTROL_WMASK 16'h3fff
`define GPC_IRQ_RESET 2'h0
`define GPC_NUM_PINS 2
`define GPC_PIN_ONE 0
`define GPC_PIN_TWO 1

// Pin function codes
`define GPC_FN_OUTPUT 6'h00
`define GPC_FN_IRQ 6'h02
`define GPC_FN_INPUT 6'h03
`define GPC_FN_BIAS_CURRENT 6'h04
`define GPC_FN_BIAS_SHORT 6'h05
`define GPC_FN_DIGITAL_MIC 6'h06
`define GPC_FN_FLL_LOCK 6'h08
`define GPC_FN_FLL_CLOCK 6'h09

// Indices of the synchronised side sources
`define GPC_NUM_SRC 5
`define GPC_SRC_BIAS_CURRENT 0
`define GPC_SRC_BIAS_SHORT 1
`define GPC_SRC_FLL_LOCK 2
`define GPC_SRC_FLL_CLOCK 3
`define GPC_SRC_MIC_SIDE_CLOCK 4

// Timing
`define GPC_MCLK_MHZ 10
`define GPC_DEBOUNCE_US 1000

`endif

// ### include/gpc_pkg.sv
package gpc_pkg;

   // Layout of one pin control register
   typedef struct packed {
      logic [1:0] reserved;
      logic [5:0] function_select;
      logic direction;
      logic drive_type;
      logic input_polarity;
      logic out_level;
      logic pulldown_en;
      logic pullup_en;
      logic irq_trigger;
      logic debounce_en;
   } gpc_ctrl_type;

   typedef logic [15:0] gpc_word_type;

endpackage

// ### include/gpc_pin_if.sv
`timescale 1ns/10ps
interface gpc_pin_if;
   gpc_pkg::gpc_ctrl_type ctrl;
   logic pad_in;
   logic pad_sync;
   logic active;
   logic irq_event;

   modport host (
      output ctrl,
      output pad_in,
      input pad_sync,
      input active,
      input irq_event
   );

   modport pin (
      input ctrl,
      input pad_in,
      output pad_sync,
      output active,
      output irq_event
   );
endinterface

// ### hdl/gpc_pin.sv
`timescale 1ns/10ps
module gpc_pin #(
   parameter int DEB_CYCLES = 1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Link to the register block
   gpc_pin_if.pin bus
);

   localparam int CW = $clog2(DEB_CYCLES + 1);

   logic s1_r, s2_r, s3_r;
   logic agree_r, agree_nxt;
   logic db_r, db_nxt;
   logic act_r, act_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;

   always_comb begin
      // Only the second and third stages are compared; the first may be metastable
      agree_nxt = (s2_r == s3_r) ? s2_r : agree_r;
      db_nxt = db_r;
      cnt_nxt = cnt_r;
      if (!bus.ctrl.debounce_en) begin
         db_nxt = agree_r;
         cnt_nxt = '0;
      end else if (agree_r == db_r) begin
         cnt_nxt = '0;
      end else if (cnt_r == CW'(DEB_CYCLES - 1)) begin
         db_nxt = agree_r;
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + 1'b1;
      end
      act_nxt = bus.ctrl.input_polarity ? db_r : ~db_r;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         agree_r <= 1'b0;
         db_r <= 1'b0;
         act_r <= 1'b0;
         cnt_r <= '0;
      end else begin
         s1_r <= bus.pad_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         agree_r <= agree_nxt;
         db_r <= db_nxt;
         act_r <= act_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign bus.pad_sync = agree_r;
   assign bus.active = act_r;
   // Edge mode flags only the rise into the active level
   assign bus.irq_event = bus.ctrl.irq_trigger ? (act_nxt & ~act_r) : act_nxt;

endmodule

// ### hdl/gpc_top.sv
`timescale 1ns/10ps
`include "gpc_regs.svh"
module gpc_top #(
   parameter int DEBOUNCE_CYCLES = `GPC_DEBOUNCE_US * `GPC_MCLK_MHZ
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Sources from the rest of the codec
   input wire logic mic_bias_current_det,
   input wire logic mic_bias_short_det,
   input wire logic fll_lock,
   input wire logic fll_clock,
   input wire logic digital_mic_side_clock,
   // Pins
   input wire logic [1:0] pin_in,
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe,
   output logic [1:0] pin_pullup_en,
   output logic [1:0] pin_pulldown_en,
   // Results
   output logic digital_mic_data_in,
   output logic [1:0] pin_level,
   output logic irq
);

   gpc_pkg::gpc_ctrl_type ctrl_r [`GPC_NUM_PINS];
   gpc_pkg::gpc_ctrl_type ctrl_nxt [`GPC_NUM_PINS];
   logic [1:0] stat_r, stat_nxt;
   logic [1:0] mask_r, mask_nxt;
   logic [1:0] events;
   logic [1:0] active;
   logic [1:0] pad_sync;
   logic [15:0] rdata_r, rdata_nxt;
   logic irq_r, irq_nxt;
   logic dmic_r, dmic_nxt;
   logic [`GPC_NUM_SRC-1:0] src_raw;
   logic [`GPC_NUM_SRC-1:0] src_val;

   assign src_raw[`GPC_SRC_BIAS_CURRENT] = mic_bias_current_det;
   assign src_raw[`GPC_SRC_BIAS_SHORT] = mic_bias_short_det;
   assign src_raw[`GPC_SRC_FLL_LOCK] = fll_lock;
   assign src_raw[`GPC_SRC_FLL_CLOCK] = fll_clock;
   assign src_raw[`GPC_SRC_MIC_SIDE_CLOCK] = digital_mic_side_clock;

   // Side sources come from other clock domains: three stages, change on agreement
   genvar k;
   generate
      for (k = 0; k < `GPC_NUM_SRC; k++) begin : g_src
         logic s1_r, s2_r, s3_r;
         logic val_r, val_nxt;

         always_comb begin
            val_nxt = (s2_r == s3_r) ? s2_r : val_r;
         end

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               val_r <= 1'b0;
            end else begin
               s1_r <= src_raw[k];
               s2_r <= s1_r;
               s3_r <= s2_r;
               val_r <= val_nxt;
            end
         end

         assign src_val[k] = val_r;
      end
   endgenerate

   // Register file and interrupt logic
   always_comb begin
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      rdata_nxt = 16'h0000;
      stat_nxt = stat_r;
      if (reg_wr) begin
         case (reg_addr)
            `GPC_ADDR_PIN_ONE_CONTROL: begin
               ctrl_nxt[`GPC_PIN_ONE] = reg_wdata & `GPC_CONTROL_WMASK;
            end
            `GPC_ADDR_PIN_TWO_CONTROL: begin
               ctrl_nxt[`GPC_PIN_TWO] = reg_wdata & `GPC_CONTROL_WMASK;
            end
            `GPC_ADDR_IRQ_STATUS: begin
               stat_nxt = stat_r & ~reg_wdata[1:0];
            end
            `GPC_ADDR_IRQ_MASK: begin
               mask_nxt = reg_wdata[1:0];
            end
            default: begin
               mask_nxt = mask_r;
            end
         endcase
      end
      // A new event wins over a clear in the same cycle
      stat_nxt = stat_nxt | events;
      if (reg_rd) begin
         case (reg_addr)
            `GPC_ADDR_PIN_ONE_CONTROL: begin
               rdata_nxt = ctrl_r[`GPC_PIN_ONE];
            end
            `GPC_ADDR_PIN_TWO_CONTROL: begin
               rdata_nxt = ctrl_r[`GPC_PIN_TWO];
            end
            `GPC_ADDR_IRQ_STATUS: begin
               rdata_nxt = {14'h0000, stat_r};
            end
            `GPC_ADDR_IRQ_MASK: begin
               rdata_nxt = {14'h0000, mask_r};
            end
            `GPC_ADDR_PIN_STATE: begin
               rdata_nxt = {14'h0000, active};
            end
            default: begin
               rdata_nxt = 16'h0000;
            end
         endcase
      end
      irq_nxt = |(stat_nxt & mask_nxt);
      // Pin two carries microphone data only while that function is selected
      dmic_nxt = 1'b0;
      if (ctrl_r[`GPC_PIN_TWO].function_select == `GPC_FN_DIGITAL_MIC) begin
         dmic_nxt = pad_sync[`GPC_PIN_TWO];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r[`GPC_PIN_ONE] <= gpc_pkg::gpc_ctrl_type'(`GPC_PIN_ONE_CONTROL_RESET);
         ctrl_r[`GPC_PIN_TWO] <= gpc_pkg::gpc_ctrl_type'(`GPC_PIN_TWO_CONTROL_RESET);
         stat_r <= `GPC_IRQ_RESET;
         mask_r <= `GPC_IRQ_RESET;
         rdata_r <= 16'h0000;
         irq_r <= 1'b0;
         dmic_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
         dmic_r <= dmic_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq = irq_r;
   assign digital_mic_data_in = dmic_r;

   // Per-pin input path and output drive
   genvar i;
   generate
      for (i = 0; i < `GPC_NUM_PINS; i++) begin : g_pin
         gpc_pin_if pin_if ();
         logic want;
         logic level;
         logic drive;
         logic out_r, out_nxt;
         logic oe_r, oe_nxt;

         assign pin_if.ctrl = ctrl_r[i];
         assign pin_if.pad_in = pin_in[i];

         gpc_pin #(
            .DEB_CYCLES(DEBOUNCE_CYCLES)
         ) u_pin (
            .mclk(mclk),
            .rst_n(rst_n),
            .bus(pin_if.pin)
         );

         assign active[i] = pin_if.active;
         assign pad_sync[i] = pin_if.pad_sync;
         // Only a pin set up as an input raises events
         assign events[i] = pin_if.irq_event &
            (ctrl_r[i].function_select == `GPC_FN_INPUT);

         always_comb begin
            want = 1'b0;
            level = 1'b0;
            case (ctrl_r[i].function_select)
               `GPC_FN_OUTPUT: begin
                  want = 1'b1;
                  level = ctrl_r[i].out_level;
               end
               `GPC_FN_IRQ: begin
                  want = 1'b1;
                  level = irq_r;
               end
               `GPC_FN_INPUT: begin
                  want = 1'b0;
               end
               `GPC_FN_BIAS_CURRENT: begin
                  want = 1'b1;
                  level = src_val[`GPC_SRC_BIAS_CURRENT];
               end
               `GPC_FN_BIAS_SHORT: begin
                  want = 1'b1;
                  level = src_val[`GPC_SRC_BIAS_SHORT];
               end
               `GPC_FN_DIGITAL_MIC: begin
                  // Pin two takes data in here, so only pin one drives
                  want = (i == `GPC_PIN_ONE);
                  level = src_val[`GPC_SRC_MIC_SIDE_CLOCK];
               end
               `GPC_FN_FLL_LOCK: begin
                  want = 1'b1;
                  level = src_val[`GPC_SRC_FLL_LOCK];
               end
               `GPC_FN_FLL_CLOCK: begin
                  // Resampled on mclk: only clocks well below half of mclk pass cleanly
                  want = 1'b1;
                  level = src_val[`GPC_SRC_FLL_CLOCK];
               end
               default: begin
                  // Reserved codes leave the pin undriven
                  want = 1'b0;
               end
            endcase
            drive = want & ~ctrl_r[i].direction;
            if (ctrl_r[i].drive_type) begin
               out_nxt = 1'b0;
               oe_nxt = drive & ~level;
            end else begin
               out_nxt = level;
               oe_nxt = drive;
            end
         end

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               out_r <= 1'b0;
               oe_r <= 1'b0;
            end else begin
               out_r <= out_nxt;
               oe_r <= oe_nxt;
            end
         end

         assign pin_out[i] = out_r;
         assign pin_oe[i] = oe_r;
         assign pin_pulldown_en[i] = ctrl_r[i].pulldown_en;
         assign pin_pullup_en[i] = ctrl_r[i].pullup_en;
         assign pin_level[i] = pin_if.active;
      end
   endgenerate

endmodule

// ### testbench/gpc_properties.sv
`timescale 1ns/10ps
module gpc_properties (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Pins and results
   input wire logic fll_lock,
   input wire logic [1:0] pin_in,
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe,
   input wire logic [1:0] pin_pullup_en,
   input wire logic [1:0] pin_pulldown_en,
   input wire logic digital_mic_data_in
);
   // Control words rebuilt from writes only, so a stuck register shows
   logic [15:0] c1_r, c2_r, c1_nxt, c2_nxt;
   logic [5:0] f1, f2;
   always_comb begin
      c1_nxt = c1_r;
      c2_nxt = c2_r;
      if (reg_wr && reg_addr == 8'h74) c1_nxt = reg_wdata & 16'h3fff;
      if (reg_wr && reg_addr == 8'h75) c2_nxt = reg_wdata & 16'h3fff;
      f1 = c1_r[13:8];
      f2 = c2_r[13:8];
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         c1_r <= 16'h00a8;
         c2_r <= 16'h00a8;
      end else begin
         c1_r <= c1_nxt;
         c2_r <= c2_nxt;
      end
   end
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_lock_held;
      (!c1_r[7] && !c1_r[6] && f1 == 6'h08 && $stable(fll_lock)) [*6];
   endsequence
   sequence s_mic_held;
      (f2 == 6'h06 && $stable(pin_in[1])) [*6];
   endsequence
   // Pull enables follow the control bits directly, with no extra register stage
   a_ctrl_readback: assert property (reg_rd && reg_addr == 8'h74 |=> reg_rdata == $past(c1_r))
      else $error("readback wrong");
   a_pull_up: assert property (pin_pullup_en == {c2_r[2], c1_r[2]})
      else $error("pull-up wrong");
   a_pull_down: assert property (pin_pulldown_en == {c2_r[3], c1_r[3]})
      else $error("pull-down wrong");
   a_input_quiet: assert property ((pin_oe & $past({c2_r[7] || f2 == 6'h06, c1_r[7] || f1 == 6'h03})) == 2'h0)
      else $error("input pin drives");
   a_cmos_level: assert property ($past(!c1_r[7] && !c1_r[6] && f1 == 6'h00) |-> pin_oe[0] && pin_out[0] == $past(c1_r[4]))
      else $error("level wrong");
   a_open_drain: assert property ($past(!c1_r[7] && c1_r[6] && f1 == 6'h00) |-> !pin_out[0] && pin_oe[0] == !$past(c1_r[4]))
      else $error("open drain wrong");
   a_lock_out: assert property (s_lock_held |-> pin_out[0] == fll_lock)
      else $error("lock out wrong");
   a_mic_data: assert property (s_mic_held |-> digital_mic_data_in == pin_in[1])
      else $error("mic data wrong");
endmodule
bind gpc_top gpc_properties u_gpc_properties (
   .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fll_lock, .pin_in,
   .pin_out, .pin_oe, .pin_pullup_en, .pin_pulldown_en, .digital_mic_data_in
);

// ### testbench/gpc_pad_model.sv
`timescale 1ns/10ps
module gpc_pad_model (
   // Clock
   input wire logic mclk,
   // Pads from the block
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe,
   input wire logic [1:0] pin_pullup_en,
   input wire logic [1:0] pin_pulldown_en,
   // Outside driver
   input wire logic [1:0] ext_en,
   input wire logic [1:0] ext_val,
   // Resolved levels
   output logic [1:0] pin_in
);
   logic [1:0] float_r = 2'h1;
   // A pad nobody holds wanders, so a missing pull never hides
   always @(posedge mclk) float_r <= ~float_r;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pin_pullup_en[i]) pin_in[i] = 1'b1;
         else if (pin_pulldown_en[i]) pin_in[i] = 1'b0;
         else pin_in[i] = float_r[i];
      end
   end
endmodule

// ### testbench/tb.sv
`timescale 1ns/10ps
module tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [4:0] src = 5'h00;
   logic [1:0] ext_en = 2'h0;
   logic [1:0] ext_val = 2'h0;
   logic [15:0] reg_rdata, v;
   logic [1:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_pulldown_en, pin_level;
   logic digital_mic_data_in, irq, e;
   logic rd_seen = 1'b0;
   logic [15:0] exp_q [$];
   logic [5:0] codes [8] = '{6'h00, 6'h02, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h03};
   logic [7:0] ad [2] = '{8'h74, 8'h75};
   int seed = 38;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   // Short debounce keeps the glitch test brief
   gpc_top #(.DEBOUNCE_CYCLES(4)) u_gpc_top (
      .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .mic_bias_current_det(src[0]), .mic_bias_short_det(src[1]), .fll_lock(src[2]),
      .fll_clock(src[3]), .digital_mic_side_clock(src[4]), .pin_in, .pin_out, .pin_oe,
      .pin_pullup_en, .pin_pulldown_en, .digital_mic_data_in, .pin_level, .irq
   );
   gpc_pad_model u_gpc_pad_model (
      .mclk, .pin_out, .pin_oe, .pin_pullup_en, .pin_pulldown_en, .ext_en, .ext_val, .pin_in
   );
   initial begin
      forever #50 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      n_compared++;
      if (seen !== want) begin
         num_errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) exp_q.push_back(d);
   endtask
   task automatic pause(input int n);
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      if (rd_seen) chk(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         wrap_up;
      end
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      pause(1);
      chk(16'({pin_pulldown_en, pin_pullup_en, pin_oe}), 16'h30);
      bus(1'b0, 8'h74, 16'h00a8);
      bus(1'b0, 8'h75, 16'h00a8);
      bus(1'b0, 8'h40, 16'h0000);
      bus(1'b0, 8'h7c, 16'h0000);
      ext_en <= 2'h3;
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 8; k++) begin
            bus(1'b1, ad[p], {2'h0, codes[k], 8'h38});
            src <= 5'($random(seed));
            ext_val <= 2'($random(seed));
            pause(8);
            case (codes[k])
               6'h00: e = 1'b1;
               6'h04: e = src[0];
               6'h05: e = src[1];
               6'h06: e = src[4];
               6'h08: e = src[2];
               6'h09: e = src[3];
               default: e = 1'b0;
            endcase
            if (codes[k] != 6'h03 && !(p == 1 && codes[k] == 6'h06)) begin
               chk(16'({pin_oe[p], pin_out[p]}), 16'({1'b1, e}));
            end
            chk(16'(pin_oe[p] || digital_mic_data_in), 16'(p == 1 && codes[k] == 6'h06
               ? ext_val[1] : codes[k] != 6'h03));
         end
      end
      bus(1'b1, 8'h75, 16'h00a8);
      bus(1'b1, 8'h74, 16'h03a0);
      ext_val <= 2'h0;
      pause(10);
      bus(1'b1, 8'h7a, 16'h0003);
      bus(1'b1, 8'h7b, 16'h0001);
      bus(1'b0, 8'h7a, 16'h0000);
      ext_val <= 2'h1;
      pause(10);
      chk(16'(irq), 16'h1);
      bus(1'b1, 8'h7b, 16'h0000);
      pause(1);
      chk(16'(irq), 16'h0);
      bus(1'b1, 8'h7a, 16'h0001);
      bus(1'b0, 8'h7a, 16'h0001);
      bus(1'b1, 8'h74, 16'h03a2);
      pause(2);
      bus(1'b1, 8'h7a, 16'h0001);
      bus(1'b0, 8'h7a, 16'h0000);
      ext_val <= 2'h0;
      pause(10);
      bus(1'b0, 8'h7c, 16'h0000);
      ext_val <= 2'h1;
      pause(10);
      bus(1'b0, 8'h7a, 16'h0001);
      bus(1'b1, 8'h74, 16'h0380);
      ext_val <= 2'h0;
      pause(10);
      chk(16'(pin_level[0]), 16'h1);
      bus(1'b0, 8'h7c, 16'h0001);
      bus(1'b1, 8'h74, 16'h03a1);
      pause(10);
      bus(1'b0, 8'h7c, 16'h0000);
      ext_val <= 2'h1;
      bus(1'b0, 8'h7c, 16'h0000);
      bus(1'b0, 8'h7c, 16'h0000);
      ext_val <= 2'h0;
      pause(12);
      bus(1'b0, 8'h7c, 16'h0000);
      ext_val <= 2'h1;
      pause(14);
      bus(1'b0, 8'h7c, 16'h0001);
      bus(1'b1, 8'h74, 16'h0050);
      pause(3);
      chk(16'({pin_oe[0], pin_out[0]}), 16'h0);
      bus(1'b1, 8'h74, 16'h0040);
      pause(3);
      chk(16'({pin_oe[0], pin_out[0]}), 16'h2);
      for (int i = 0; i < 6; i++) begin
         v = 16'($random(seed));
         v[13:8] = codes[v[2:0]];
         bus(1'b1, ad[i % 2], v);
         bus(1'b0, ad[i % 2], v & 16'h3fff);
      end
      pause(2);
      wrap_up;
   end
endmodule
